// [bench/link_partner.sv]
// Purpose: far-side link controller model
// Assumes: device oe_n high means the device has released the pin
// Notes: resolves the bit clock and frame sync wire levels
`timescale 1ns/1ps
module link_partner #(
   parameter int FRAME_BITS = 256,
   parameter int SYNC_BITS = 16
) (
   // device drive
   input wire logic bit_clk_out,
   input wire logic bit_clk_oe_n,
   input wire logic sync_out,
   input wire logic sync_oe_n,
   // resolved wires
   output logic bit_clk_wire,
   output logic sync_wire
);
   logic src_clk = 1'b0;
   logic sync_q = 1'b0;
   int bit_cnt = 0;
   ////////////////////////////////////////
   // bit clock source, phase unrelated to mclk
   initial begin
      #3.3;
      forever #32 src_clk = ~src_clk;
   end
   assign bit_clk_wire = bit_clk_oe_n ? src_clk : bit_clk_out;
   // frame sync, one frame every FRAME_BITS bits
   always @(posedge bit_clk_wire) begin
      bit_cnt <= (bit_cnt == FRAME_BITS - 1) ? 0 : bit_cnt + 1;
      sync_q <= (bit_cnt < SYNC_BITS);
   end
   assign sync_wire = sync_oe_n ? sync_q : sync_out;
endmodule

// [bench/tb_serial_mode_strap_and_pin_roles.sv]
// Purpose: self-checking bench for strap latch and pin roles
// Assumes: zero-wait AHB-Lite slave, link partner on the far side
// Notes: each strap code follows a fresh power-on reset
`timescale 1ns/1ps
module tb_serial_mode_strap_and_pin_roles
   import pin_role_pkg::*;
;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic reset_pin_n = 1'b0;
   logic hsel = 1'b0;
   logic [7:0] haddr = 8'h00;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] hwdata = 32'h0;
   logic hready;
   logic hreadyout;
   logic hresp;
   logic [31:0] hrdata;
   logic [31:0] rd;
   logic [7:0] gpio_in = 8'hFF;
   logic [7:0] gpio_out;
   logic [7:0] gpio_oe_n;
   logic [7:0] gpio_pullup_en;
   logic mon_bit = 1'b0;
   logic mic_sel, xtal_need, bclk_out, bclk_oe_n, bclk_w;
   logic sync_o, sync_oe_n, sync_w;
   logic locked, ac_en, dsp_en, bit_rise, frame_start, irq;
   logic [3:0] slot;
   link_mode_e link_mode;
   int n_mismatch = 0;
   int n_tests = 0;
   int cyc = 0;
   assign hready = hreadyout;
   ////////////////////////////////////////
   pin_role_top u_dut (
      .mclk, .rst_n, .reset_pin_n, .hsel, .haddr, .htrans, .hwrite,
      .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .gpio_in,
      .gpio_out, .gpio_oe_n, .gpio_pullup_en,
      .monitor_output_pin(mon_bit), .microphone_analog_input(mic_sel),
      .crystal_clock_needed(xtal_need), .bit_clk_in(bclk_w),
      .bit_clk_out(bclk_out), .bit_clk_oe_n(bclk_oe_n),
      .sync_in(sync_w), .sync_out(sync_o), .sync_oe_n(sync_oe_n),
      .link_mode, .mode_locked(locked), .ac97_engine_en(ac_en),
      .dsp_engine_en(dsp_en), .sample_slot(slot),
      .link_bit_rise(bit_rise), .link_frame_start(frame_start), .irq
   );
   link_partner u_far (
      .bit_clk_out(bclk_out), .bit_clk_oe_n(bclk_oe_n),
      .sync_out(sync_o), .sync_oe_n(sync_oe_n),
      .bit_clk_wire(bclk_w), .sync_wire(sync_w)
   );
   ////////////////////////////////////////
   initial begin
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_mismatch++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
      if (n_mismatch == 0 && n_tests > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic chk1(input string nm, input logic e, input logic g);
      n_tests++;
      if (g !== e) begin
         n_mismatch++;
         $display("unexpected %s: expected %b seen %b", nm, e, g);
      end
   endtask
   task automatic cycles(input int n);
      repeat (n) @(posedge mclk);
   endtask
   // single AHB-Lite transfer, called just after a rising edge
   task automatic bus(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      @(posedge mclk);
      while (hready !== 1'b1) @(posedge mclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge mclk);
      while (hready !== 1'b1) @(posedge mclk);
      rd = hrdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rdchk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(nm, e, rd);
   endtask
   task automatic power_up(input logic [1:0] s);
      rst_n <= 1'b0;
      reset_pin_n <= 1'b0;
      gpio_in <= {4'hF, s, 2'h3};
      cycles(20);
      rst_n <= 1'b1;
      cycles(5);
   endtask
   // bits counted between two frame starts
   task automatic frame_check();
      int n;
      n = 0;
      while (frame_start !== 1'b1 && n < 9000) begin
         @(posedge mclk);
         n++;
      end
      n = 0;
      @(posedge mclk);
      while (frame_start !== 1'b1) begin
         @(posedge mclk);
         if (bit_rise === 1'b1) n++;
      end
      chk("frame_bits", 32'h100, 32'(n));
   endtask
   // bit clock toggles in 1000 mclk cycles against a window
   task automatic rate_check(input string nm, input int lo, input int hi);
      int t;
      logic last;
      t = 0;
      last = bclk_out;
      repeat (1000) begin
         @(posedge mclk);
         if (bclk_out !== last) t++;
         last = bclk_out;
      end
      chk1(nm, 1'b1, t >= lo && t <= hi);
   endtask
   ////////////////////////////////////////
   initial begin
      for (int i = 3; i >= 0; i--) begin
         logic [1:0] s;
         s = 2'(i);
         power_up(s);
         if (i == 3) begin
            chk("pullups", 32'hFF, {24'h0, gpio_pullup_en});
            chk("oe_reset", 32'hFF, {24'h0, gpio_oe_n});
            chk("slot_reset", 32'h5, {28'h0, slot});
            wr(ADDR_GPIO_DIR, 32'hFF);
            cycles(3);
            chk("oe_prelock", 32'h0E, {24'h0, gpio_oe_n});
         end
         reset_pin_n <= 1'b1;
         cycles(10);
         chk("mode", {30'h0, ~s}, {30'h0, link_mode});
         chk1("locked", 1'b1, locked);
         chk1("bclk_oe_n", s == 2'b01 || s == 2'b10, bclk_oe_n);
         chk1("sync_oe_n", s != 2'b00, sync_oe_n);
         chk1("ac_en", s != 2'b00, ac_en);
         chk1("dsp_en", s == 2'b00, dsp_en);
         chk1("xtal_need", s == 2'b11 || s == 2'b00, xtal_need);
         rdchk("mode_reg", ADDR_MODE, {29'h0, 1'b1, ~s});
         gpio_in <= {4'hF, ~s, 2'h3};
         reset_pin_n <= 1'b0;
         cycles(5);
         reset_pin_n <= 1'b1;
         cycles(10);
         chk("mode_kept", {30'h0, ~s}, {30'h0, link_mode});
         if (i >= 2) frame_check();
         if (i == 3) rate_check("bitclk_rate", 122, 123);
         if (i == 0) rate_check("dsp_bitclk_rate", 40, 41);
      end
      for (int k = 0; k < 4; k++) begin
         wr(ADDR_CTRL, 32'(k) << CTRL_SLOT_LSB);
         cycles(2);
         chk("slot", k == 1 ? 32'hA : k == 2 ? 32'hB : 32'h5,
             {28'h0, slot});
      end
      wr(ADDR_GPIO_DIR, 32'hFF);
      wr(ADDR_CTRL, 32'h1);
      cycles(3);
      chk1("mic", 1'b1, mic_sel);
      chk("oe_mic", 32'h02, {24'h0, gpio_oe_n});
      rdchk("gpio_in_mic", ADDR_GPIO_IN, 32'hFD);
      wr(ADDR_CTRL, 32'h4);
      for (int k = 0; k < 2; k++) begin
         mon_bit <= k[0];
         cycles(3);
         chk1("mon_out", k[0], gpio_out[PIN_MON]);
         chk1("mon_oe_n", 1'b0, gpio_oe_n[PIN_MON]);
      end
      gpio_in[0] <= 1'b0;
      wr(ADDR_WAKE_POL, 32'h1);
      wr(ADDR_WAKE_MASK, 32'h1);
      wr(ADDR_IRQ_ENABLE, 32'h2);
      wr(ADDR_CTRL, 32'h2);
      bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
      chk1("wake_idle", 1'b0, rd[IRQ_WAKE]);
      gpio_in[0] <= 1'b1;
      cycles(8);
      chk1("alert_hi", 1'b1, gpio_out[PIN_ALERT]);
      chk1("alert_oe_n", 1'b0, gpio_oe_n[PIN_ALERT]);
      chk1("irq_wake", 1'b1, irq);
      gpio_in[0] <= 1'b0;
      cycles(8);
      chk1("alert_lo", 1'b0, gpio_out[PIN_ALERT]);
      wr(ADDR_IRQ_CLEAR, 32'h2);
      cycles(2);
      chk1("irq_clr", 1'b0, irq);
      bus(1'b0, ADDR_IRQ_STATUS, 32'h0);
      chk1("wake_stat", 1'b0, rd[IRQ_WAKE]);
      wr(ADDR_IRQ_ENABLE, 32'h1);
      cycles(2);
      chk1("irq_lock", 1'b1, irq);
      wr(ADDR_IRQ_ENABLE, 32'h0);
      cycles(2);
      chk1("irq_mask", 1'b0, irq);
      rdchk("unmapped", 8'h3C, 32'h0);
      wr(ADDR_GPIO_PULL, 32'h0);
      cycles(2);
      chk("pull_off", 32'h0, {24'h0, gpio_pullup_en});
      chk1("hresp", 1'b0, hresp);
      end_sim();
   end
endmodule

// [rtl/nco_div.sv]
`timescale 1ns/1ps
// Purpose: phase accumulator giving one-cycle enable pulses
// Assumes: step sets the pulse rate as a fraction of mclk
// Notes: carry out of the accumulator is the pulse
module nco_div
   import pin_role_pkg::*;
(
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // divider link
   tick_if.gen t
);
   logic [NCO_W-1:0] acc_q;
   logic [NCO_W:0] sum;

   assign sum = {1'b0, acc_q} + {1'b0, t.step};

   always_ff @(posedge mclk) begin
      if (!rst_n || !t.run) begin
         acc_q <= '0;
         t.tick <= 1'b0;
      end else begin
         acc_q <= sum[NCO_W-1:0];
         t.tick <= sum[NCO_W];
      end
   end
endmodule

// [rtl/pin_role_pkg.sv]
// Purpose: constants shared by the strap latch and pin role block
// Assumes: mclk at 200 MHz, registers reached over AHB-Lite
// Notes: byte addresses of one aligned word per register
//
// Summary of operation
// - straps latched once, at first reset release
// - strap pair decodes to three codec modes or DSP
// - strap pins pulled up, floating gives primary
// - strap pins become general I/O after latch
// - strap capture needs no running crystal clock; crystal_clock_needed is still set while awaiting the latch
// - all eight pins default inputs with pull-ups
// - alert role drives pin 3 on wake match
// - pin 1 input only, optional microphone route
// - monitor role drives monitor bit on pin 4
// - primary mode drives bit clock at 12.288 MHz
// - controller drives 48 kHz frame sync, device accepts
// - secondary modes take bit clock as input
// - secondary modes need no crystal clock unless a wake mask bit is set
// - sample slot 5 by default, else 10 or 11
// - frame sync output in DSP, input otherwise
// - bit clock output primary and DSP, else input
package pin_role_pkg;

   typedef enum logic [1:0] {
      MODE_PRIMARY,
      MODE_SECOND_01,
      MODE_SECOND_10,
      MODE_DSP
   } link_mode_e;

   typedef enum {ST_WAIT_RELEASE, ST_LOCKED} latch_state_e;

   // register byte addresses
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_GPIO_DIR = 8'h04;
   localparam logic [7:0] ADDR_GPIO_OUT = 8'h08;
   localparam logic [7:0] ADDR_GPIO_PULL = 8'h0C;
   localparam logic [7:0] ADDR_GPIO_IN = 8'h10;
   localparam logic [7:0] ADDR_WAKE_MASK = 8'h14;
   localparam logic [7:0] ADDR_WAKE_POL = 8'h18;
   localparam logic [7:0] ADDR_MODE = 8'h1C;
   localparam logic [7:0] ADDR_IRQ_STATUS = 8'h20;
   localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h24;
   localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h28;

   // control fields
   localparam int CTRL_MIC_BIT = 0;
   localparam int CTRL_ALERT_BIT = 1;
   localparam int CTRL_MON_BIT = 2;
   localparam int CTRL_SLOT_LSB = 4;
   localparam int MODE_LOCK_BIT = 2;

   // interrupt bits
   localparam int IRQ_W = 3;
   localparam int IRQ_LOCKED = 0;
   localparam int IRQ_WAKE = 1;
   localparam int IRQ_FRAME = 2;

   // pins
   localparam int GPIO_W = 8;
   localparam int PIN_MIC = 1;
   localparam int PIN_STRAP_LO = 2;
   localparam int PIN_ALERT = 3;
   localparam int PIN_MON = 4;

   // reset values
   localparam logic [7:0] PULL_RESET = 8'hFF;
   localparam logic [7:0] DIR_RESET = 8'h00;
   localparam logic [1:0] SLOT_SEL_RESET = 2'h0;

   // sample slots
   localparam logic [3:0] SLOT_DEFAULT = 4'h5;
   localparam logic [3:0] SLOT_ALT_A = 4'hA;
   localparam logic [3:0] SLOT_ALT_B = 4'hB;

   // link timing
   localparam longint MCLK_KHZ = 200000;
   localparam longint AC_BITCLK_KHZ = 12288;
   localparam longint DSP_BITCLK_KHZ = 4096;
   localparam int NCO_W = 24;
   localparam logic [NCO_W-1:0] AC_STEP =
      NCO_W'((2 * AC_BITCLK_KHZ * (64'h1 << NCO_W)) / MCLK_KHZ);
   localparam logic [NCO_W-1:0] DSP_STEP =
      NCO_W'((2 * DSP_BITCLK_KHZ * (64'h1 << NCO_W)) / MCLK_KHZ);
   localparam int DSP_FRAME_W = 9;
   localparam logic [DSP_FRAME_W-1:0] DSP_FRAME_LAST = 9'h1FF;

endpackage

// [rtl/pin_role_top.sv]
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
// Purpose: strap mode latch, pin roles and link direction
// Assumes: rst_n is the power-on reset, reset_pin_n the pin
// Notes: AHB-Lite slave, zero wait states, always OKAY
module pin_role_top
   import pin_role_pkg::*;
(
   // clock and power-on reset
   input wire logic mclk,
   input wire logic rst_n,
   // reset / power-down pin
   input wire logic reset_pin_n,
   // AHB-Lite slave
   input wire logic hsel,
   input wire logic [7:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // general purpose pins
   input wire logic [GPIO_W-1:0] gpio_in,
   output logic [GPIO_W-1:0] gpio_out,
   output logic [GPIO_W-1:0] gpio_oe_n,
   output logic [GPIO_W-1:0] gpio_pullup_en,
   // codec side
   input wire logic monitor_output_pin,
   output logic microphone_analog_input,
   output logic crystal_clock_needed,
   // link pins
   input wire logic bit_clk_in,
   output logic bit_clk_out,
   output logic bit_clk_oe_n,
   input wire logic sync_in,
   output logic sync_out,
   output logic sync_oe_n,
   // engine side
   output link_mode_e link_mode,
   output logic mode_locked,
   output logic ac97_engine_en,
   output logic dsp_engine_en,
   output logic [3:0] sample_slot,
   output logic link_bit_rise,
   output logic link_frame_start,
   // interrupt
   output logic irq
);
   latch_state_e state_q;
   link_mode_e mode_q;
   logic [GPIO_W-1:0] gpio_s;
   logic rpin_s, rpin_prev_q, bclk_s, bclk_prev_q, sync_s, sync_prev_q;
   logic [7:0] ctrl_q, dir_q, out_q, pull_q, wmask_q, wpol_q;
   logic [IRQ_W-1:0] ista_q, ien_q, iset;
   logic wake_q, locked, run, master, bclk_q, dsync_q, bit_rise, frame;
   logic [DSP_FRAME_W-1:0] bitcnt_q;
   logic wr_pend_q;
   logic [7:0] wr_addr_q;
   logic [31:0] hrdata_q;
   logic [GPIO_W-1:0] pin_out_d, pin_oe_n_d, pin_out_q, pin_oe_n_q;
   logic [3:0] slot_q;
   logic irq_q, clr_hit;
   tick_if tk ();

   ////////////////////////////////////////////////////////////////
   // pin synchronisers
   sync2 #(.W(GPIO_W + 3)) u_sync (
      .mclk(mclk),
      .d({gpio_in, reset_pin_n, bit_clk_in, sync_in}),
      .q({gpio_s, rpin_s, bclk_s, sync_s})
   );

   ////////////////////////////////////////////////////////////////
   // strap latch
   assign locked = (state_q == ST_LOCKED);

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         rpin_prev_q <= 1'b0;
      end else begin
         rpin_prev_q <= rpin_s;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         state_q <= ST_WAIT_RELEASE;
         mode_q <= MODE_PRIMARY;
      end else begin
         case (state_q)
            ST_WAIT_RELEASE: begin
               if (rpin_s && !rpin_prev_q) begin
                  mode_q <= link_mode_e'(~gpio_s[PIN_ALERT:PIN_STRAP_LO]);
                  state_q <= ST_LOCKED;
               end
            end
            ST_LOCKED: state_q <= ST_LOCKED;
            default: state_q <= ST_WAIT_RELEASE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////
   // link clock and frame sync
   assign master = (mode_q == MODE_PRIMARY) || (mode_q == MODE_DSP);
   assign run = locked && rpin_s && master;
   assign tk.run = run;
   assign tk.step = (mode_q == MODE_DSP) ? DSP_STEP : AC_STEP;

   nco_div u_nco (
      .mclk(mclk),
      .rst_n(rst_n),
      .t(tk.gen)
   );

   always_ff @(posedge mclk) begin
      if (!rst_n || !run) begin
         bclk_q <= 1'b0;
      end else if (tk.tick) begin
         bclk_q <= !bclk_q;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         bclk_prev_q <= 1'b0;
         sync_prev_q <= 1'b0;
      end else begin
         bclk_prev_q <= bclk_s;
         sync_prev_q <= sync_s;
      end
   end

   // slave edges from the sampled pin, master edges from the divider
   assign bit_rise = master ? (run && tk.tick && !bclk_q)
                            : (locked && bclk_s && !bclk_prev_q);

   always_ff @(posedge mclk) begin
      if (!rst_n || !(run && mode_q == MODE_DSP)) begin
         bitcnt_q <= '0;
         dsync_q <= 1'b0;
      end else if (bit_rise) begin
         bitcnt_q <= bitcnt_q + 1'b1;
         dsync_q <= (bitcnt_q == DSP_FRAME_LAST);
      end
   end

   assign frame = (mode_q == MODE_DSP)
      ? (bit_rise && bitcnt_q == DSP_FRAME_LAST)
      : (locked && sync_s && !sync_prev_q);

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         bit_clk_out <= 1'b0;
         bit_clk_oe_n <= 1'b1;
         sync_out <= 1'b0;
         sync_oe_n <= 1'b1;
         link_bit_rise <= 1'b0;
         link_frame_start <= 1'b0;
      end else begin
         bit_clk_out <= bclk_q;
         bit_clk_oe_n <= !(locked && master);
         sync_out <= dsync_q;
         sync_oe_n <= !(locked && mode_q == MODE_DSP);
         link_bit_rise <= bit_rise;
         link_frame_start <= frame;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ac97_engine_en <= 1'b0;
         dsp_engine_en <= 1'b0;
         crystal_clock_needed <= 1'b0;
         slot_q <= SLOT_DEFAULT;
      end else begin
         ac97_engine_en <= locked && mode_q != MODE_DSP;
         dsp_engine_en <= locked && mode_q == MODE_DSP;
         crystal_clock_needed <= master || (|wmask_q);
         case (ctrl_q[CTRL_SLOT_LSB +: 2])
            2'h1: slot_q <= SLOT_ALT_A;
            2'h2: slot_q <= SLOT_ALT_B;
            default: slot_q <= SLOT_DEFAULT;
         endcase
      end
   end

   assign link_mode = mode_q;
   assign mode_locked = locked;
   assign sample_slot = slot_q;

   ////////////////////////////////////////////////////////////////
   // pin roles
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wake_q <= 1'b0;
      end else begin
         wake_q <= |(wmask_q & ~(gpio_s ^ wpol_q));
      end
   end

   always_comb begin
      pin_out_d = out_q;
      pin_oe_n_d = ~dir_q;
      pin_oe_n_d[PIN_MIC] = 1'b1;
      if (!locked) begin
         pin_oe_n_d[PIN_ALERT:PIN_STRAP_LO] = 2'h3;
      end else if (ctrl_q[CTRL_ALERT_BIT]) begin
         pin_out_d[PIN_ALERT] = wake_q;
         pin_oe_n_d[PIN_ALERT] = 1'b0;
      end
      if (ctrl_q[CTRL_MON_BIT]) begin
         pin_out_d[PIN_MON] = monitor_output_pin;
         pin_oe_n_d[PIN_MON] = 1'b0;
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         pin_out_q <= '0;
         pin_oe_n_q <= '1;
      end else begin
         pin_out_q <= pin_out_d;
         pin_oe_n_q <= pin_oe_n_d;
      end
   end

   assign gpio_out = pin_out_q;
   assign gpio_oe_n = pin_oe_n_q;
   assign gpio_pullup_en = locked ? pull_q : PULL_RESET;
   assign microphone_analog_input = ctrl_q[CTRL_MIC_BIT];

   ////////////////////////////////////////////////////////////////
   // AHB-Lite slave
   function automatic logic [31:0] reg_read(input logic [7:0] a);
      case (a)
         ADDR_CTRL: reg_read = {24'h0, ctrl_q};
         ADDR_GPIO_DIR: reg_read = {24'h0, dir_q};
         ADDR_GPIO_OUT: reg_read = {24'h0, out_q};
         ADDR_GPIO_PULL: reg_read = {24'h0, pull_q};
         ADDR_GPIO_IN: reg_read = {24'h0, gpio_s &
            ~(ctrl_q[CTRL_MIC_BIT] ? 8'(1 << PIN_MIC) : 8'h00)};
         ADDR_WAKE_MASK: reg_read = {24'h0, wmask_q};
         ADDR_WAKE_POL: reg_read = {24'h0, wpol_q};
         ADDR_MODE: reg_read = {29'h0, locked, mode_q};
         ADDR_IRQ_STATUS: reg_read = {29'h0, ista_q};
         ADDR_IRQ_ENABLE: reg_read = {29'h0, ien_q};
         default: reg_read = 32'h0;
      endcase
   endfunction

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hrdata_q <= 32'h0;
      end else begin
         wr_pend_q <= 1'b0;
         if (hsel && htrans[1] && hready) begin
            wr_pend_q <= hwrite;
            wr_addr_q <= haddr;
            if (!hwrite) begin
               hrdata_q <= reg_read(haddr);
            end
         end
      end
   end

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ctrl_q <= {2'h0, SLOT_SEL_RESET, 4'h0};
         dir_q <= DIR_RESET;
         out_q <= 8'h00;
         pull_q <= PULL_RESET;
         wmask_q <= 8'h00;
         wpol_q <= 8'h00;
         ien_q <= '0;
      end else if (wr_pend_q) begin
         case (wr_addr_q)
            ADDR_CTRL: ctrl_q <= hwdata[7:0];
            ADDR_GPIO_DIR: dir_q <= hwdata[7:0];
            ADDR_GPIO_OUT: out_q <= hwdata[7:0];
            ADDR_GPIO_PULL: pull_q <= hwdata[7:0];
            ADDR_WAKE_MASK: wmask_q <= hwdata[7:0];
            ADDR_WAKE_POL: wpol_q <= hwdata[7:0];
            ADDR_IRQ_ENABLE: ien_q <= hwdata[IRQ_W-1:0];
            default: ien_q <= ien_q;
         endcase
      end
   end

   assign hrdata = hrdata_q;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   ////////////////////////////////////////////////////////////////
   // interrupts, set wins over clear
   assign clr_hit = wr_pend_q && (wr_addr_q == ADDR_IRQ_CLEAR);
   assign iset[IRQ_LOCKED] = (state_q == ST_WAIT_RELEASE)
      && rpin_s && !rpin_prev_q;
   assign iset[IRQ_WAKE] = wmask_q != 8'h00
      && |(wmask_q & ~(gpio_s ^ wpol_q)) && !wake_q;
   assign iset[IRQ_FRAME] = frame;

   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         ista_q <= '0;
         irq_q <= 1'b0;
      end else begin
         ista_q <= (ista_q & ~(clr_hit ? hwdata[IRQ_W-1:0] : '0)) | iset;
         irq_q <= |(ista_q & ien_q);
      end
   end

   assign irq = irq_q;

   ////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_mode_held: assert property (locked && $past(locked) |->
      $stable(mode_q)) else $error("latched mode changed");
   a_strap_decode: assert property (iset[IRQ_LOCKED] |=>
      mode_q == link_mode_e'(~$past(gpio_s[PIN_ALERT:PIN_STRAP_LO])))
      else $error("strap decode wrong");
   a_strap_pullup: assert property (!locked |->
      gpio_pullup_en[PIN_ALERT:PIN_STRAP_LO] == 2'h3)
      else $error("strap pull-ups off before latch");
   a_strap_input: assert property (!locked && !$past(locked) |=>
      gpio_oe_n[PIN_ALERT:PIN_STRAP_LO] == 2'h3)
      else $error("strap pin driven before latch");
   a_pins_default: assert property ($past(!rst_n) |->
      gpio_oe_n == 8'hFF && gpio_pullup_en == PULL_RESET)
      else $error("pins not inputs with pull-ups");
   a_alert_drive: assert property (locked && ctrl_q[CTRL_ALERT_BIT]
      |=> !gpio_oe_n[PIN_ALERT] && gpio_out[PIN_ALERT] == $past(wake_q))
      else $error("alert pin not following wake");
   a_pin1_input: assert property (gpio_oe_n[PIN_MIC])
      else $error("pin 1 driven");
   a_monitor_drive: assert property (ctrl_q[CTRL_MON_BIT] |=>
      gpio_out[PIN_MON] == $past(monitor_output_pin))
      else $error("monitor pin wrong");
   a_bitclk_rate: assert property (disable iff (!rst_n || !run)
      run && mode_q == MODE_PRIMARY && tk.tick |=>
      !tk.tick [*7] ##[1:2] tk.tick)
      else $error("primary bit clock rate wrong");
   a_bitclk_dir: assert property (locked && $past(locked) |->
      bit_clk_oe_n == !master) else $error("bit clock direction wrong");
   a_sync_dir: assert property (locked && $past(locked) |->
      sync_oe_n == (mode_q != MODE_DSP)) else $error("sync direction");
   a_frame_flag: assert property (frame && mode_q != MODE_DSP |=>
      ista_q[IRQ_FRAME]) else $error("frame sync not flagged");
   a_slot_default: assert property (ctrl_q[CTRL_SLOT_LSB +: 2] == 2'h0
      |=> sample_slot == SLOT_DEFAULT) else $error("slot not 5");

   c_primary: cover property (iset[IRQ_LOCKED] ##1 mode_q == MODE_PRIMARY);
   c_dsp: cover property (dsync_q && !sync_oe_n);
   c_second: cover property (locked && mode_q == MODE_SECOND_10 && bit_rise);
   c_wake: cover property (irq && ista_q[IRQ_WAKE]);
endmodule

// [rtl/sync2.sv]
`timescale 1ns/1ps
// Purpose: two flip-flop synchroniser for pin levels
// Assumes: inputs asynchronous to mclk
// Notes: first stage feeds only the second stage
module sync2 #(
   parameter int W = 1
) (
   // clock
   input wire logic mclk,
   // data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge mclk) begin
      meta_q <= d;
      q <= meta_q;
   end
endmodule

// [rtl/tick_if.sv]
`timescale 1ns/1ps
// Purpose: carries a divider step and its enable pulse
// Assumes: one clock domain
// Notes: gen side drives the tick, user side the step
interface tick_if;
   import pin_role_pkg::*;
   logic [NCO_W-1:0] step;
   logic run;
   logic tick;
   modport gen (input step, input run, output tick);
   modport user (output step, output run, input tick);
endinterface
